// file: core/art5_defs.svh
`ifndef ART5_DEFS_SVH
`define ART5_DEFS_SVH

// ****************************************
// register addresses on the core register bus
// ****************************************
`define ART5_ADDR_CTRL_A 8'hc0
`define ART5_ADDR_RLD_LO 8'hd2
`define ART5_ADDR_RLD_HI 8'hd3
`define ART5_ADDR_CNT_LO 8'hd4
`define ART5_ADDR_CNT_HI 8'hd5
`define ART5_ADDR_CTRL_B 8'hf1

// ****************************************
// control a bit positions
// ****************************************
`define ART5_BIT_FLAG_H 7
`define ART5_BIT_FLAG_L 6
`define ART5_BIT_LEN 5
`define ART5_BIT_CEN 4
`define ART5_BIT_SPLIT 3
`define ART5_BIT_RUN 2
`define ART5_XSEL_MSB 1
`define ART5_XSEL_LSB 0

// ****************************************
// control b field positions
// ****************************************
`define ART5_RLSEL_MSB 7
`define ART5_RLSEL_LSB 5
`define ART5_CSEL_MSB 2
`define ART5_CSEL_LSB 0

// ****************************************
// reset values and codes
// ****************************************
`define ART5_RST_BYTE 8'h00
`define ART5_RST_WORD 16'h0000
`define ART5_RST_XSEL 2'h0
`define ART5_RST_RLSEL 3'h0
`define ART5_RST_CSEL 3'h0
`define ART5_RLSEL_UNIT_A 3'h1
`define ART5_RLSEL_UNIT_B 3'h2
`define ART5_RLSEL_UNIT_D 3'h3
`define ART5_CSEL_SOF 3'h3
`define ART5_BYTE_MAX 8'hff
`define ART5_WORD_MAX 16'hffff

`endif

// file: core/art5_pkg.sv
package art5_pkg;

  typedef struct packed {
    logic high_byte_overflow_flag;
    logic low_byte_overflow_flag;
    logic low_byte_irq_enable;
    logic capture_enable;
    logic split_mode_select;
    logic run_control;
    logic [1:0] external_clock_select;
    logic [2:0] force_reload_select;
    logic [2:0] capture_source_select;
    logic [15:0] reload;
    logic [15:0] count;
    logic [7:0] rdata;
  } art5_state_t;

  typedef struct packed {
    logic [6:0] level_prev;
  } art5_edge_state_t;

endpackage

// file: core/art5_capture_edge.sv
`timescale 1ns/1ps
`include "art5_defs.svh"

module art5_capture_edge
  import art5_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [2:0] capture_source_select,
  input wire logic timer_input_pin,
  input wire logic low_frequency_oscillator,
  input wire logic analog_compare_output,
  input wire logic usb_sof_pulse,
  input wire logic logic_unit_a_output,
  input wire logic logic_unit_b_output,
  input wire logic logic_unit_c_output,
  input wire logic logic_unit_d_output,
  output logic capture_event
);

  art5_edge_state_t st_reg;
  art5_edge_state_t st_next;
  logic [7:0] level_now;
  logic [7:0] falls;

  // every level source is tracked, so a change of select gives no false edge
  always_comb begin
    level_now = {logic_unit_d_output, logic_unit_c_output, logic_unit_b_output,
                 logic_unit_a_output, 1'b0, analog_compare_output,
                 low_frequency_oscillator, timer_input_pin};
    st_next.level_prev = {level_now[7:4], level_now[2:0]};
    falls = {st_reg.level_prev[6:3], 1'b0, st_reg.level_prev[2:0]} & ~level_now;
    // start-of-frame is already an event pulse, not a level
    if (capture_source_select == `ART5_CSEL_SOF) begin
      capture_event = usb_sof_pulse;
    end else begin
      capture_event = falls[capture_source_select];
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule

// file: core/art5_timer.sv
`timescale 1ns/1ps
`include "art5_defs.svh"

// Behaviour
// - reload registers hold reload or captured bytes
// - one 16-bit counter or two 8-bit
// - high overflow sets flag, requests interrupt
// - low byte overflow always sets low flag
// - low flag interrupts when low enable set
// - capture copies count into reload pair
// - run gates all, or only high in split
// - external clock select with per-byte choices
// - selected high signal forces counter reload
// - force codes map to logic units a,b,d
// - capture sources mapped, falling edges except frame
// - capture select bits 2:0, reset zero
module art5_timer
  import art5_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr_en,
  input wire logic sfr_rd_en,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic [3:0] ext_clock_tick,
  input wire logic low_byte_clock_select,
  input wire logic high_byte_clock_select,
  input wire logic timer_irq_enable,
  input wire logic timer_input_pin,
  input wire logic low_frequency_oscillator,
  input wire logic analog_compare_output,
  input wire logic usb_sof_pulse,
  input wire logic logic_unit_a_output,
  input wire logic logic_unit_b_output,
  input wire logic logic_unit_c_output,
  input wire logic logic_unit_d_output,
  output logic timer_irq_req
);

  art5_state_t st_reg;
  art5_state_t st_next;
  logic ext_tick;
  logic tick_lo;
  logic tick_hi;
  logic en_lo;
  logic en_hi;
  logic ovf_lo;
  logic ovf_hi;
  logic force_reload;
  logic cap_event;
  logic cap_take;
  logic wr_ctrl_a;

  // ****************************************
  // capture source
  // ****************************************
  art5_capture_edge u_edge (
    .clk_sys(clk_sys),
    .reset(reset),
    .capture_source_select(st_reg.capture_source_select),
    .timer_input_pin(timer_input_pin),
    .low_frequency_oscillator(low_frequency_oscillator),
    .analog_compare_output(analog_compare_output),
    .usb_sof_pulse(usb_sof_pulse),
    .logic_unit_a_output(logic_unit_a_output),
    .logic_unit_b_output(logic_unit_b_output),
    .logic_unit_c_output(logic_unit_c_output),
    .logic_unit_d_output(logic_unit_d_output),
    .capture_event(cap_event)
  );

  // ****************************************
  // count engine and register file
  // ****************************************
  always_comb begin
    st_next = st_reg;
    wr_ctrl_a = sfr_wr_en && (sfr_addr == `ART5_ADDR_CTRL_A);
    ext_tick = ext_clock_tick[st_reg.external_clock_select];
    tick_lo = low_byte_clock_select ? ext_tick : 1'b1;
    tick_hi = high_byte_clock_select ? ext_tick : 1'b1;
    if (st_reg.split_mode_select) begin
      en_lo = tick_lo;
      en_hi = st_reg.run_control && tick_hi;
    end else begin
      en_lo = st_reg.run_control && tick_lo;
      en_hi = en_lo && (st_reg.count[7:0] == `ART5_BYTE_MAX);
    end
    ovf_lo = en_lo && (st_reg.count[7:0] == `ART5_BYTE_MAX);
    ovf_hi = en_hi && (st_reg.count[15:8] == `ART5_BYTE_MAX);
    unique case (st_reg.force_reload_select)
      `ART5_RLSEL_UNIT_A: force_reload = logic_unit_a_output;
      `ART5_RLSEL_UNIT_B: force_reload = logic_unit_b_output;
      `ART5_RLSEL_UNIT_D: force_reload = logic_unit_d_output;
      default: force_reload = 1'b0;
    endcase
    cap_take = st_reg.capture_enable && cap_event;

    // capture mode wraps to zero, the reload pair holds captures there
    if (en_lo) begin
      if (!st_reg.capture_enable &&
          (st_reg.split_mode_select ? ovf_lo : ovf_hi)) begin
        st_next.count[7:0] = st_reg.reload[7:0];
      end else begin
        st_next.count[7:0] = st_reg.count[7:0] + 8'h01;
      end
    end
    if (en_hi) begin
      if (!st_reg.capture_enable && ovf_hi) begin
        st_next.count[15:8] = st_reg.reload[15:8];
      end else begin
        st_next.count[15:8] = st_reg.count[15:8] + 8'h01;
      end
    end
    if (force_reload) begin
      st_next.count = st_reg.reload;
    end

    // register writes; hardware flag sets win over the write
    if (sfr_wr_en) begin
      unique case (sfr_addr)
        `ART5_ADDR_CTRL_A: begin
          st_next.high_byte_overflow_flag = sfr_wdata[`ART5_BIT_FLAG_H];
          st_next.low_byte_overflow_flag = sfr_wdata[`ART5_BIT_FLAG_L];
          st_next.low_byte_irq_enable = sfr_wdata[`ART5_BIT_LEN];
          st_next.capture_enable = sfr_wdata[`ART5_BIT_CEN];
          st_next.split_mode_select = sfr_wdata[`ART5_BIT_SPLIT];
          st_next.run_control = sfr_wdata[`ART5_BIT_RUN];
          st_next.external_clock_select = sfr_wdata[`ART5_XSEL_MSB:`ART5_XSEL_LSB];
        end
        `ART5_ADDR_RLD_LO: st_next.reload[7:0] = sfr_wdata;
        `ART5_ADDR_RLD_HI: st_next.reload[15:8] = sfr_wdata;
        `ART5_ADDR_CNT_LO: st_next.count[7:0] = sfr_wdata;
        `ART5_ADDR_CNT_HI: st_next.count[15:8] = sfr_wdata;
        `ART5_ADDR_CTRL_B: begin
          st_next.force_reload_select = sfr_wdata[`ART5_RLSEL_MSB:`ART5_RLSEL_LSB];
          st_next.capture_source_select = sfr_wdata[`ART5_CSEL_MSB:`ART5_CSEL_LSB];
        end
        default: begin
        end
      endcase
    end
    if (cap_take) begin
      st_next.reload = st_reg.count;
    end
    if (ovf_hi || cap_take) begin
      st_next.high_byte_overflow_flag = 1'b1;
    end
    if (ovf_lo) begin
      st_next.low_byte_overflow_flag = 1'b1;
    end

    // read data lands one cycle after the strobe; unmapped reads zero
    if (sfr_rd_en) begin
      unique case (sfr_addr)
        `ART5_ADDR_CTRL_A: st_next.rdata = {st_reg.high_byte_overflow_flag,
            st_reg.low_byte_overflow_flag, st_reg.low_byte_irq_enable,
            st_reg.capture_enable, st_reg.split_mode_select,
            st_reg.run_control, st_reg.external_clock_select};
        `ART5_ADDR_RLD_LO: st_next.rdata = st_reg.reload[7:0];
        `ART5_ADDR_RLD_HI: st_next.rdata = st_reg.reload[15:8];
        `ART5_ADDR_CNT_LO: st_next.rdata = st_reg.count[7:0];
        `ART5_ADDR_CNT_HI: st_next.rdata = st_reg.count[15:8];
        `ART5_ADDR_CTRL_B: st_next.rdata = {st_reg.force_reload_select, 2'h0,
            st_reg.capture_source_select};
        default: st_next.rdata = `ART5_RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_reg.high_byte_overflow_flag <= 1'b0;
      st_reg.low_byte_overflow_flag <= 1'b0;
      st_reg.low_byte_irq_enable <= 1'b0;
      st_reg.capture_enable <= 1'b0;
      st_reg.split_mode_select <= 1'b0;
      st_reg.run_control <= 1'b0;
      st_reg.external_clock_select <= `ART5_RST_XSEL;
      st_reg.force_reload_select <= `ART5_RST_RLSEL;
      st_reg.capture_source_select <= `ART5_RST_CSEL;
      st_reg.reload <= `ART5_RST_WORD;
      st_reg.count <= `ART5_RST_WORD;
      st_reg.rdata <= `ART5_RST_BYTE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sfr_rdata = st_reg.rdata;
  // flags stay until software writes them to zero
  assign timer_irq_req = timer_irq_enable && (st_reg.high_byte_overflow_flag ||
      (st_reg.low_byte_overflow_flag && st_reg.low_byte_irq_enable));

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  property p_capture_copy;
    cap_take |=> st_reg.reload == $past(st_reg.count);
  endproperty
  a_capture_copy: assert property (p_capture_copy) else $error("capture lost");

  property p_high_flag;
    ovf_hi |=> st_reg.high_byte_overflow_flag;
  endproperty
  a_high_flag: assert property (p_high_flag) else $error("high flag not set");

  property p_low_flag;
    ovf_lo |=> st_reg.low_byte_overflow_flag;
  endproperty
  a_low_flag: assert property (p_low_flag) else $error("low flag not set");

  property p_low_irq;
    ovf_lo && st_reg.low_byte_irq_enable && timer_irq_enable && !wr_ctrl_a
      |=> timer_irq_req;
  endproperty
  a_low_irq: assert property (p_low_irq) else $error("low irq missing");

  property p_high_hold;
    !st_reg.run_control && !force_reload && !sfr_wr_en |=>
      st_reg.count[15:8] == $past(st_reg.count[15:8]);
  endproperty
  a_high_hold: assert property (p_high_hold) else $error("high byte ran");

  property p_split_low_free;
    st_reg.split_mode_select && !st_reg.run_control && tick_lo && !force_reload &&
      !sfr_wr_en && st_reg.count[7:0] != `ART5_BYTE_MAX |=>
      st_reg.count[7:0] == $past(st_reg.count[7:0]) + 8'h01;
  endproperty
  a_split_low_free: assert property (p_split_low_free) else $error("low byte stalled");

  property p_force;
    force_reload && !sfr_wr_en |=> st_reg.count == $past(st_reg.reload);
  endproperty
  a_force: assert property (p_force) else $error("force reload missed");

  property p_count16;
    !st_reg.split_mode_select && st_reg.run_control && tick_lo && !force_reload &&
      !sfr_wr_en && st_reg.count != `ART5_WORD_MAX |=>
      st_reg.count == $past(st_reg.count) + 16'h0001;
  endproperty
  a_count16: assert property (p_count16) else $error("16-bit step wrong");

  property p_reload16;
    !st_reg.split_mode_select && ovf_hi && !st_reg.capture_enable &&
      !force_reload && !sfr_wr_en |=> st_reg.count == $past(st_reg.reload);
  endproperty
  a_reload16: assert property (p_reload16) else $error("overflow reload wrong");

  property p_flag_sticky;
    st_reg.high_byte_overflow_flag && !wr_ctrl_a |=> st_reg.high_byte_overflow_flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag self-cleared");

  c_split_low_ovf: cover property (st_reg.split_mode_select && ovf_lo);
  c_full_ovf: cover property (!st_reg.split_mode_select && ovf_hi);
  c_capture: cover property (cap_take);
  c_force: cover property (force_reload);

endmodule

// file: verif/tb_top.sv
`timescale 1ns/1ps
`include "art5_defs.svh"

module tb_top
  import art5_pkg::*;
;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic lsel = 1'b0;
  logic hsel = 1'b0;
  logic ien = 1'b0;
  logic [3:0] tick = 4'h0;
  logic [7:0] src = 8'h00;
  logic [7:0] rdata;
  logic irq;
  int error_cnt = 0;
  int compares = 0;
  logic [15:0] m_cnt;
  logic [15:0] m_rld;
  logic [7:0] m_a;
  logic [7:0] m_b;
  logic [7:0] m_rd;
  logic [7:0] m_prev;
  logic [7:0] regs [7] = '{8'hc0, 8'hd2, 8'hd3, 8'hd4, 8'hd5, 8'hf1, 8'h7e};
  wire m_irq = ien & (m_a[7] | (m_a[6] & m_a[5]));

  always #2 clk_sys = ~clk_sys;

  // random external ticks keep both clock paths busy
  always @(posedge clk_sys) tick <= 4'($urandom());

  art5_timer dut_u (.clk_sys(clk_sys), .reset(reset), .sfr_addr(addr), .sfr_wr_en(wr),
    .sfr_rd_en(rd), .sfr_wdata(wdata), .sfr_rdata(rdata), .ext_clock_tick(tick),
    .low_byte_clock_select(lsel), .high_byte_clock_select(hsel), .timer_irq_enable(ien),
    .timer_input_pin(src[0]), .low_frequency_oscillator(src[1]),
    .analog_compare_output(src[2]), .usb_sof_pulse(src[3]),
    .logic_unit_a_output(src[4]), .logic_unit_b_output(src[5]),
    .logic_unit_c_output(src[6]), .logic_unit_d_output(src[7]), .timer_irq_req(irq));

  // ****************************************
  // reference model
  // ****************************************
  always @(posedge clk_sys or posedge reset) begin : model
    logic tl, th, f, ev;
    logic [1:0] h;
    logic [15:0] c0;
    if (reset) begin
      m_cnt = 16'h0000;
      m_rld = 16'h0000;
      m_a = 8'h00;
      m_b = 8'h00;
      m_rd = 8'h00;
      m_prev = 8'h00;
    end else begin
      h = 2'b00;
      c0 = m_cnt;
      if (rd) begin
        case (addr)
          8'hc0: m_rd = m_a;
          8'hd2: m_rd = m_rld[7:0];
          8'hd3: m_rd = m_rld[15:8];
          8'hd4: m_rd = m_cnt[7:0];
          8'hd5: m_rd = m_cnt[15:8];
          8'hf1: m_rd = m_b;
          default: m_rd = 8'h00;
        endcase
      end
      tl = lsel ? tick[m_a[1:0]] : 1'b1;
      th = hsel ? tick[m_a[1:0]] : 1'b1;
      f = (m_b[7:5] == 3'h1 && src[4]) || (m_b[7:5] == 3'h2 && src[5])
        || (m_b[7:5] == 3'h3 && src[7]);
      ev = m_a[4] && (m_b[2:0] == 3'h3 ? src[3] : m_prev[m_b[2:0]] && !src[m_b[2:0]]);
      m_prev = src;
      // overflow flags are taken from the count path even when a force wins
      if (!m_a[3]) begin
        if (m_a[2] && tl) begin
          if (m_cnt[7:0] == 8'hff) h[0] = 1'b1;
          if (m_cnt == 16'hffff) begin
            h[1] = 1'b1;
            m_cnt = m_a[4] ? 16'h0000 : m_rld;
          end else begin
            m_cnt = m_cnt + 16'h0001;
          end
        end
      end else begin
        if (tl) begin
          if (m_cnt[7:0] == 8'hff) h[0] = 1'b1;
          m_cnt[7:0] = m_cnt[7:0] == 8'hff ? (m_a[4] ? 8'h00 : m_rld[7:0]) : m_cnt[7:0] + 8'h01;
        end
        if (m_a[2] && th) begin
          if (m_cnt[15:8] == 8'hff) h[1] = 1'b1;
          m_cnt[15:8] = m_cnt[15:8] == 8'hff ? (m_a[4] ? 8'h00 : m_rld[15:8])
            : m_cnt[15:8] + 8'h01;
        end
      end
      if (f) begin
        m_cnt = m_rld;
      end
      if (wr) begin
        case (addr)
          8'hc0: m_a = wdata;
          8'hd2: m_rld[7:0] = wdata;
          8'hd3: m_rld[15:8] = wdata;
          8'hd4: m_cnt[7:0] = wdata;
          8'hd5: m_cnt[15:8] = wdata;
          8'hf1: m_b = wdata & 8'he7;
          default: ;
        endcase
      end
      if (ev) m_rld = c0;
      h[1] = h[1] | ev;
      m_a[7:6] = m_a[7:6] | h;
    end
  end

  // ****************************************
  // bus tasks and checking
  // ****************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask

  task automatic rd_all();
    foreach (regs[i]) begin
      @(posedge clk_sys);
      addr <= regs[i];
      rd <= 1'b1;
      @(posedge clk_sys);
      rd <= 1'b0;
      #1;
      check(rdata, m_rd);
    end
    check({7'h0, irq}, {7'h0, m_irq});
  endtask

  task automatic summarize();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    error_cnt++;
    summarize();
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    void'($urandom(16));
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    ien <= 1'b1;
    rd_all();
    $display("test 1 done");
    for (int i = 0; i < 16; i++) begin
      wr_reg(regs[$urandom() % 6], 8'($urandom()));
      rd_all();
    end
    $display("test 2 done");
    wr_reg(8'hf1, 8'h00);
    wr_reg(8'hd2, 8'($urandom()));
    wr_reg(8'hd3, 8'($urandom()));
    wr_reg(8'hd4, 8'hf0);
    wr_reg(8'hd5, 8'hff);
    wr_reg(8'hc0, 8'h04);
    repeat (20) @(posedge clk_sys);
    rd_all();
    wr_reg(8'hc0, 8'h00);
    rd_all();
    $display("test 3 done");
    lsel <= 1'b1;
    hsel <= 1'b1;
    for (int x = 0; x < 4; x++) begin
      wr_reg(8'hc0, 8'h28 | 8'(x) | 8'((x & 1) << 2));
      repeat (300) @(posedge clk_sys);
      rd_all();
    end
    $display("test 4 done");
    lsel <= 1'b0;
    wr_reg(8'hc0, 8'h00);
    for (int s = 0; s < 8; s++) begin
      wr_reg(8'hf1, 8'(s << 5));
      // fresh count, so every forced reload shows
      wr_reg(8'hd4, 8'($urandom()));
      src <= 8'hb0;
      repeat (3) @(posedge clk_sys);
      src <= 8'h00;
      rd_all();
    end
    $display("test 5 done");
    // count runs, so a capture on the wrong edge lands a different value
    wr_reg(8'hc0, 8'h14);
    for (int s = 0; s < 8; s++) begin
      wr_reg(8'hf1, 8'(s));
      wr_reg(8'hd4, 8'($urandom()));
      wr_reg(8'hd5, 8'($urandom()));
      src <= 8'h01 << s;
      @(posedge clk_sys);
      src <= 8'h00;
      repeat (3) @(posedge clk_sys);
      rd_all();
      wr_reg(8'hc0, 8'h14);
    end
    $display("test 6 done");
    summarize();
  end
endmodule
